/* core/spimd_port.sv */
`timescale 1ns/1ps
`default_nettype none
module spimd_port (
	input  wire logic                           clk,
	input  wire logic                           nrst,
	input  wire logic                           sck_i,
	input  wire logic                           mosi_i,
	input  wire logic                           miso_i,
	input  wire logic                           slave_select_n_i,
	output spimd_pkg::spimd_pin_s               mosi_pin,
	output spimd_pkg::spimd_pin_s               miso_pin,
	output spimd_pkg::spimd_pin_s               sck_pin,
	output spimd_pkg::spimd_pin_s               select_pin,
	output logic                                select_pin_routed,
	input  wire logic                           ctl_wr,
	input  wire spimd_pkg::spimd_ctl_s          ctl_wdata,
	output spimd_pkg::spimd_ctl_s               ctl_rdata,
	input  wire logic                           data_wr,
	input  wire logic [spimd_pkg::BYTE_W-1:0]   data_wdata,
	output logic                                data_accepted,
	output logic      [spimd_pkg::BYTE_W-1:0]   rx_data,
	output logic                                transfer_done_flag,
	input  wire logic                           done_clr,
	output logic                                mode_fault_flag,
	input  wire logic                           fault_clr,
	output logic                                busy
);

	typedef struct packed {
		spimd_pkg::spimd_ctl_s               ctl;
		logic                                done;
		logic                                fault;
		logic [spimd_pkg::BYTE_W-1:0]        rx;
		logic [spimd_pkg::BYTE_W-1:0]        tx;
		logic                                tx_full;
		logic [spimd_pkg::BYTE_W-1:0]        sh;
		logic [spimd_pkg::CNT_W-1:0]         cnt;
		spimd_pkg::spimd_mst_e               st;
		logic [spimd_pkg::DIV_W-1:0]         div;
		logic                                sck;
		logic                                smp;
		logic                                seen;
		logic                                nss_prev;
	} spimd_sys_s;

	typedef struct packed {
		logic [spimd_pkg::BYTE_W-1:0] sh;
		logic [spimd_pkg::CNT_W-1:0]  cnt;
	} spimd_lnk_s;

	typedef struct packed {
		logic [spimd_pkg::BYTE_W-1:0] rx;
		logic                         tgl;
	} spimd_evt_s;

	spimd_sys_s q;
	spimd_sys_s d;
	spimd_lnk_s lq;
	spimd_lnk_s ld;
	spimd_evt_s eq;
	spimd_evt_s ed;

	logic [spimd_pkg::SYNC_W-1:0] sync_o;
	logic                         miso_s;
	logic                         nss_s;
	logic                         tgl_s;
	logic                         nss_fall;
	logic                         slave_done;
	logic                         en;
	logic                         is_master;
	logic                         mode_in;
	logic                         selected;
	logic                         lnk_rst_n;
	logic [spimd_pkg::BYTE_W-1:0] lnk_src;

	// Select line synchronised
	// Sync before edges
	spimd_sync u_sync (
		.clk      (clk),
		.nrst     (nrst),
		.async_in ({eq.tgl, slave_select_n_i, miso_i}),
		.sync_out (sync_o)
	);

	assign miso_s     = sync_o[0];
	assign nss_s      = sync_o[1];
	assign tgl_s      = sync_o[2];
	assign en         = q.ctl.port_enable_bit;
	assign is_master  = q.ctl.master_enable_bit;
	assign mode_in    = (q.ctl.select_mode_field == spimd_pkg::SEL_4WIRE_IN);
	assign nss_fall   = q.nss_prev & ~nss_s;
	assign slave_done = tgl_s ^ q.seen;

	assign selected = (q.ctl.select_mode_field == spimd_pkg::SEL_3WIRE)
		| (mode_in & ~slave_select_n_i);

	assign lnk_rst_n = nrst & en & ~is_master & selected;

	always_comb begin
		d          = q;
		d.nss_prev = nss_s;
		d.seen     = tgl_s;
		if (ctl_wr) begin
			d.ctl = ctl_wdata;
		end
		if (done_clr) begin
			d.done = 1'b0;
		end
		if (fault_clr) begin
			d.fault = 1'b0;
		end
		case (q.st)
			spimd_pkg::M_IDLE: begin
				d.sck = 1'b0;
				if (is_master && en && q.tx_full) begin
					d.sh      = q.tx;
					d.tx_full = 1'b0;
					d.cnt     = spimd_pkg::FIRST_BIT;
					d.div     = '0;
					d.st      = spimd_pkg::M_LOW;
				end
			end
			spimd_pkg::M_LOW: begin
				d.div = q.div + 4'h1;
				if (q.div == spimd_pkg::DIV_LAST) begin
					d.div = '0;
					d.sck = 1'b1;
					d.smp = miso_s;
					d.st  = spimd_pkg::M_HIGH;
				end
			end
			spimd_pkg::M_HIGH: begin
				d.div = q.div + 4'h1;
				if (q.div == spimd_pkg::DIV_LAST) begin
					d.div = '0;
					d.sck = 1'b0;
					d.sh  = {q.sh[spimd_pkg::BYTE_W-2:0], q.smp};
					d.cnt = q.cnt + 3'h1;
					d.st  = spimd_pkg::M_LOW;
					if (q.cnt == spimd_pkg::LAST_BIT) begin
						d.rx   = {q.sh[spimd_pkg::BYTE_W-2:0], q.smp};
						d.done = 1'b1;
						d.st   = spimd_pkg::M_IDLE;
					end
				end
			end
			default: begin
				d.st  = spimd_pkg::M_IDLE;
				d.sck = 1'b0;
			end
		endcase
		if (!is_master || !en) begin
			d.st  = spimd_pkg::M_IDLE;
			d.sck = 1'b0;
		end
		if (slave_done && !is_master) begin
			d.rx      = eq.rx;
			d.done    = 1'b1;
			d.tx_full = 1'b0;
		end
		if (data_wr && !q.tx_full) begin
			d.tx      = data_wdata;
			d.tx_full = 1'b1;
		end
		if (mode_in && is_master && en && nss_fall) begin
			d.ctl.master_enable_bit = 1'b0;
			d.ctl.port_enable_bit   = 1'b0;
			d.fault                 = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q          <= '0;
			q.ctl      <= spimd_pkg::CTL_RESET;
			q.st       <= spimd_pkg::M_IDLE;
			q.nss_prev <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Link side slave shifter
	always_comb begin
		lnk_src = (lq.cnt == spimd_pkg::FIRST_BIT) ? q.tx : lq.sh;
		ld      = lq;
		ed      = eq;
		ld.sh   = {lnk_src[spimd_pkg::BYTE_W-2:0], mosi_i};
		ld.cnt  = lq.cnt + 3'h1;
		if (lq.cnt == spimd_pkg::LAST_BIT) begin
			ed.rx  = {lnk_src[spimd_pkg::BYTE_W-2:0], mosi_i};
			ed.tgl = ~eq.tgl;
		end
	end

	always_ff @(posedge sck_i or negedge lnk_rst_n) begin
		if (!lnk_rst_n) begin
			lq <= '0;
		end else begin
			lq <= ld;
		end
	end

	// Event toggle survives deselection
	always_ff @(posedge sck_i or negedge nrst) begin
		if (!nrst) begin
			eq <= '0;
		end else if (lnk_rst_n) begin
			eq <= ed;
		end
	end

	assign mosi_pin.o  = q.sh[spimd_pkg::BYTE_W-1];
	assign mosi_pin.oe = is_master & en;
	assign miso_pin.o  = (lq.cnt == spimd_pkg::FIRST_BIT)
		? q.tx[spimd_pkg::BYTE_W-1] : lq.sh[spimd_pkg::BYTE_W-1];
	assign miso_pin.oe = en & ~is_master & selected;
	assign sck_pin.o   = q.sck;
	assign sck_pin.oe  = is_master & en;
	assign select_pin.o  = q.ctl.select_mode_field[spimd_pkg::SEL_LVL_BIT];
	assign select_pin.oe = q.ctl.select_mode_field[spimd_pkg::SEL_OUT_BIT];
	assign select_pin_routed  = (q.ctl.select_mode_field != spimd_pkg::SEL_3WIRE);
	assign ctl_rdata          = q.ctl;
	assign data_accepted      = data_wr & ~q.tx_full;
	assign rx_data            = q.rx;
	assign transfer_done_flag = q.done;
	assign mode_fault_flag    = q.fault;
	assign busy               = (q.st != spimd_pkg::M_IDLE) | q.tx_full;

	property p_fault;
		@(posedge clk) disable iff (!nrst)
		(mode_in && is_master && en && nss_fall) |=>
			(!ctl_rdata.master_enable_bit && !ctl_rdata.port_enable_bit && mode_fault_flag);
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault did not disable port");

	property p_mosi_dir;
		@(posedge clk) disable iff (!nrst)
		mosi_pin.oe |-> (ctl_rdata.master_enable_bit && ctl_rdata.port_enable_bit);
	endproperty
	a_mosi_dir: assert property (p_mosi_dir) else $error("master-out driven as slave");

	property p_mosi_msb;
		@(posedge clk) disable iff (!nrst)
		(q.st == spimd_pkg::M_HIGH && q.div == spimd_pkg::DIV_LAST && q.cnt != spimd_pkg::LAST_BIT)
			|=> (mosi_pin.o == $past(q.sh[spimd_pkg::BYTE_W-2]));
	endproperty
	a_mosi_msb: assert property (p_mosi_msb) else $error("master-out not next bit");

	property p_miso_z;
		@(posedge clk) disable iff (!nrst)
		(!ctl_rdata.port_enable_bit || ctl_rdata.master_enable_bit) |-> !miso_pin.oe;
	endproperty
	a_miso_z: assert property (p_miso_z) else $error("master-in driven while disabled");

	property p_sck_high;
		@(posedge clk) disable iff (!nrst)
		($rose(sck_pin.o) && ctl_rdata.master_enable_bit && ctl_rdata.port_enable_bit)
			|-> sck_pin.o [*4];
	endproperty
	a_sck_high: assert property (p_sck_high) else $error("serial clock high phase wrong");

	property p_start;
		@(posedge clk) disable iff (!nrst)
		(q.st == spimd_pkg::M_IDLE && q.tx_full && is_master && en && !nss_fall)
			|=> (q.st == spimd_pkg::M_LOW && q.sh == $past(q.tx));
	endproperty
	a_start: assert property (p_start) else $error("transfer did not start");

	property p_sel_out;
		@(posedge clk) disable iff (!nrst)
		ctl_rdata.select_mode_field[spimd_pkg::SEL_OUT_BIT] |->
			(select_pin.oe && select_pin.o == ctl_rdata.select_mode_field[spimd_pkg::SEL_LVL_BIT]);
	endproperty
	a_sel_out: assert property (p_sel_out) else $error("select output level wrong");

	property p_route;
		@(posedge clk) disable iff (!nrst)
		select_pin_routed == (ctl_rdata.select_mode_field != spimd_pkg::SEL_3WIRE);
	endproperty
	a_route: assert property (p_route) else $error("select routing wrong");

	property p_slave_done;
		@(posedge clk) disable iff (!nrst)
		(slave_done && !is_master) |=> (transfer_done_flag && rx_data == $past(eq.rx));
	endproperty
	a_slave_done: assert property (p_slave_done) else $error("slave byte not stored");

	property p_master_done;
		@(posedge clk) disable iff (!nrst)
		(q.st == spimd_pkg::M_HIGH && q.div == spimd_pkg::DIV_LAST && q.cnt == spimd_pkg::LAST_BIT
			&& is_master && en && !nss_fall) |=> (transfer_done_flag && q.st == spimd_pkg::M_IDLE);
	endproperty
	a_master_done: assert property (p_master_done) else $error("master byte end missed");

endmodule : spimd_port
`default_nettype wire

/* core/spimd_pkg.sv */
package spimd_pkg;

	localparam int unsigned BYTE_W      = 8;
	localparam int unsigned CNT_W       = 3;
	localparam int unsigned DIV_W       = 4;
	localparam int unsigned SYNC_W      = 3;
	localparam logic [1:0]  SEL_3WIRE   = 2'h0;
	localparam logic [1:0]  SEL_4WIRE_IN = 2'h1;
	localparam int unsigned SEL_OUT_BIT = 1;
	localparam int unsigned SEL_LVL_BIT = 0;
	localparam logic [CNT_W-1:0] FIRST_BIT = 3'h0;
	localparam logic [CNT_W-1:0] LAST_BIT  = 3'h7;
	// Master serial clock half period in system clocks
	localparam logic [DIV_W-1:0] HALF_PERIOD = 4'h4;
	localparam logic [DIV_W-1:0] DIV_LAST    = HALF_PERIOD - 4'h1;
	localparam logic [BYTE_W-1:0] BYTE_ZERO  = 8'h00;

	typedef struct packed {
		logic       master_enable_bit;
		logic       port_enable_bit;
		logic [1:0] select_mode_field;
	} spimd_ctl_s;

	localparam spimd_ctl_s CTL_RESET = '{1'b0, 1'b0, SEL_4WIRE_IN};

	typedef struct packed {
		logic o;
		logic oe;
	} spimd_pin_s;

	typedef enum logic [1:0] {
		M_IDLE,
		M_LOW,
		M_HIGH
	} spimd_mst_e;

endpackage : spimd_pkg

/* core/spimd_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module spimd_sync (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic [spimd_pkg::SYNC_W-1:0]  async_in,
	output logic      [spimd_pkg::SYNC_W-1:0]  sync_out
);

	typedef struct packed {
		logic [spimd_pkg::SYNC_W-1:0] meta;
		logic [spimd_pkg::SYNC_W-1:0] stable;
	} spimd_sync_s;

	spimd_sync_s q;
	spimd_sync_s d;

	// Two flops per bit
	always_comb begin
		d.meta   = async_in;
		d.stable = q.meta;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.stable;

endmodule : spimd_sync
`default_nettype wire

/* test/spimd_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module spimd_peer (
	input  wire logic       lclk,
	input  wire logic       sck_line,
	input  wire logic       mosi_line,
	input  wire logic       miso_line,
	output logic            m_sck,
	output logic            m_mosi,
	output logic            m_ss_n,
	output logic            s_miso,
	output logic [7:0]      s_rx
);
	logic [7:0] s_tx;
	initial begin
		m_sck = 1'b0;
		m_mosi = 1'b0;
		m_ss_n = 1'b1;
		s_tx = 8'h00;
		s_rx = 8'h00;
	end
	assign s_miso = s_tx[7];
	// Far slave samples on rise
	always @(posedge sck_line) begin
		s_rx <= {s_rx[6:0], mosi_line};
	end
	always @(negedge sck_line) begin
		s_tx <= {s_tx[6:0], ~s_tx[0]};
	end
	task automatic load(input logic [7:0] b);
		s_tx = b;
	endtask : load
	task automatic sel(input logic v);
		m_ss_n = v;
	endtask : sel
	// sole master, clock only in frames
	task automatic frame(input int nb, input logic on, input logic [7:0] tx,
			output logic [7:0] rx);
		m_ss_n = ~on;
		repeat (4) @(posedge lclk);
		for (int i = 0; i < nb; i++) begin
			m_mosi = tx[7-i];
			@(posedge lclk);
			rx = {rx[6:0], miso_line};
			m_sck = 1'b1;
			@(negedge lclk);
			m_sck = 1'b0;
		end
		repeat (6) @(posedge lclk);
		m_ss_n = 1'b1;
		m_mosi = ~m_mosi;
	endtask : frame
endmodule : spimd_peer
`default_nettype wire

/* test/spimd_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module spimd_port_tb;
	logic                  clk, lclk, nrst, ctl_wr, data_wr, done_clr, fault_clr;
	logic                  routed, acc, done, fault, busy;
	logic                  m_sck, m_mosi, m_ss_n, s_miso;
	logic [7:0]            data_wdata, rx_data, s_rx;
	logic [7:0]            exp_q[$];
	spimd_pkg::spimd_ctl_s ctl_wdata, ctl_rdata;
	spimd_pkg::spimd_pin_s mosi_pin, miso_pin, sck_pin, select_pin;
	logic                  sck_l, mosi_l, miso_l, ss_l;
	int                    bad_count = 0;
	int                    n_compared = 0;
	assign sck_l = sck_pin.oe ? sck_pin.o : m_sck;
	assign mosi_l = mosi_pin.oe ? mosi_pin.o : m_mosi;
	assign miso_l = miso_pin.oe ? miso_pin.o : s_miso;
	assign ss_l = select_pin.oe ? select_pin.o : m_ss_n;
	spimd_port dut (.clk, .nrst, .sck_i(sck_l), .mosi_i(mosi_l), .miso_i(miso_l),
		.slave_select_n_i(ss_l), .mosi_pin, .miso_pin, .sck_pin, .select_pin,
		.select_pin_routed(routed), .ctl_wr, .ctl_wdata, .ctl_rdata, .data_wr, .data_wdata,
		.data_accepted(acc), .rx_data, .transfer_done_flag(done), .done_clr,
		.mode_fault_flag(fault), .fault_clr, .busy);
	spimd_peer peer (.lclk, .sck_line(sck_l), .mosi_line(mosi_l), .miso_line(miso_l),
		.m_sck, .m_mosi, .m_ss_n, .s_miso, .s_rx);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #24 lclk = ~lclk;
	end
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic set_ctl(input logic m, input logic en, input logic [1:0] md);
		@(negedge clk);
		ctl_wr = 1'b1;
		ctl_wdata = '{m, en, md};
		@(negedge clk);
		ctl_wr = 1'b0;
		@(negedge clk);
	endtask : set_ctl
	task automatic wait_done;
		int n;
		n = 0;
		while (done !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 200) begin
				bad_count++;
				$display("MISMATCH done_wait expected 1 seen %b", done);
				stop_test();
			end
		end
		done_clr = 1'b1;
		@(negedge clk);
		done_clr = 1'b0;
	endtask : wait_done
	task automatic slave_byte(input logic on);
		logic [7:0] mt, st, got;
		mt = 8'($urandom);
		st = 8'($urandom);
		exp_q.push_back(mt);
		@(negedge clk);
		data_wr = 1'b1;
		data_wdata = st;
		@(negedge clk);
		data_wr = 1'b0;
		peer.frame(8, on, mt, got);
		wait_done();
		chk("slave_rx", exp_q.pop_front(), rx_data);
		chk("slave_tx", st, got);
	endtask : slave_byte
	initial begin
		logic [7:0] tb, sb;
		logic       a1, a2;
		nrst = 1'b0;
		ctl_wr = 1'b0;
		ctl_wdata = '0;
		data_wr = 1'b0;
		data_wdata = 8'h00;
		done_clr = 1'b0;
		fault_clr = 1'b0;
		void'($urandom(90));
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		chk("ctl_reset", {4'h0, spimd_pkg::CTL_RESET}, {4'h0, ctl_rdata});
		chk("miso_oe_off", 8'h00, {7'h0, miso_pin.oe});
		chk("routed_rst", 8'h01, {7'h0, routed});
		// output select used as master only
		for (int md = 0; md < 4; md++) begin
			set_ctl(1'b1, 1'b1, 2'(md));
			chk("pin_oe", {3'h0, md != 0, 3'h5, md[1]}, {3'h0, routed, mosi_pin.oe,
				miso_pin.oe, sck_pin.oe, select_pin.oe});
			if (md >= 2) chk("sel_lvl", {7'h0, md[0]}, {7'h0, select_pin.o});
			tb = 8'($urandom);
			sb = 8'($urandom);
			peer.load(sb);
			exp_q.push_back(sb);
			data_wr = 1'b1;
			data_wdata = tb;
			#1 a1 = acc;
			@(negedge clk);
			data_wdata = ~tb;
			#1 a2 = acc;
			@(negedge clk);
			data_wr = 1'b0;
			chk("accept", 8'h02, {6'h0, a1, a2});
			chk("busy", 8'h01, {7'h0, busy});
			wait_done();
			chk("master_rx", exp_q.pop_front(), rx_data);
			chk("master_tx", tb, s_rx);
		end
		set_ctl(1'b1, 1'b1, 2'h1);
		@(negedge clk);
		peer.sel(1'b0);
		repeat (6) @(negedge clk);
		chk("fault_ctl", 8'h01, {4'h0, ctl_rdata});
		chk("fault_flag", 8'h01, {7'h0, fault});
		peer.sel(1'b1);
		fault_clr = 1'b1;
		@(negedge clk);
		fault_clr = 1'b0;
		@(negedge clk);
		chk("fault_clr", 8'h00, {7'h0, fault});
		set_ctl(1'b0, 1'b1, 2'h1);
		chk("miso_desel", 8'h00, {7'h0, miso_pin.oe});
		peer.frame(8, 1'b0, 8'h3C, tb);
		repeat (10) @(negedge clk);
		chk("desel_done", 8'h00, {7'h0, done});
		peer.frame(3, 1'b1, 8'hF0, tb);
		repeat (10) @(negedge clk);
		chk("part_done", 8'h00, {7'h0, done});
		slave_byte(1'b1);
		set_ctl(1'b0, 1'b1, 2'h0);
		chk("miso_3w", 8'h01, {7'h0, miso_pin.oe});
		slave_byte(1'b0);
		set_ctl(1'b0, 1'b0, 2'h0);
		chk("miso_dis", 8'h00, {7'h0, miso_pin.oe});
		stop_test();
	end
endmodule : spimd_port_tb
`default_nettype wire
